// File: ieu_pkg.sv
// constants, opcodes and register map of the instruction execution unit
// Overview of operation
// - decrement_skip_nil writes byte minus one back, skips on zero, flags kept.
// - decrement_skip_nil_to_working puts byte minus one in working_register, skips on zero.
// - a taken skip costs a second machine cycle with a dummy instruction.
// - setting a byte loads all ones, flags unchanged.
// - setting a bit forces only that bit to one, flags unchanged.
// - increment_skip_nil writes byte plus one back, skips on wrapped zero.
// - increment_skip_nil_to_working puts byte plus one in working_register, skips on zero.
// - bit_skip_nonnil skips when the selected bit is one, flags unchanged.
// - minus_to_working stores working minus byte, updates four arithmetic flags.
// - borrow_out_bit is zero on negative result, one on zero or positive.
// - minus_to_memory stores working minus byte into memory, updates four flags.
// - immediate subtraction stores working minus constant, updates four flags.
// - nibble swap exchanges byte halves in place, flags unchanged.
// - nibble swap to working puts swapped byte in working_register only.
// - skip_on_nil skips when the whole byte is zero, flags unchanged.
// - copy_skip_on_nil copies byte to working_register, skips on zero.
// - bit_skip_nil skips when the selected bit is zero, flags unchanged.
// - table_read_current_page reads current page word, low to memory, high latched.
// - table_read_last_page reads last page word, low to memory, high latched.
// - exclusive-OR to working stores result there, updates only result_nil_flag.
// - exclusive_or_to_memory writes result to memory, updates only result_nil_flag.
// - immediate exclusive-OR stores result in working, updates only result_nil_flag.
package ieu_pkg;

   // ------------------------------------------------------------
   // opcodes, numbered in declaration order from zero
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NOP,
      OP_DEC_SKIP,
      OP_DEC_SKIP_W,
      OP_SET_BYTE,
      OP_SET_BIT,
      OP_INC_SKIP,
      OP_INC_SKIP_W,
      OP_BIT_SKIP_ONE,
      OP_SUB_W,
      OP_SUB_M,
      OP_SUB_I,
      OP_SWAP_M,
      OP_SWAP_W,
      OP_SKIP_NIL,
      OP_COPY_SKIP_NIL,
      OP_BIT_SKIP_NIL,
      OP_TAB_CUR,
      OP_TAB_LAST,
      OP_XOR_W,
      OP_XOR_M,
      OP_XOR_I
   } ieu_op_e;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_DUMMY
   } ieu_state_e;

   // ------------------------------------------------------------
   // flag positions
   // ------------------------------------------------------------
   localparam int FLG_BORROW = 0;
   localparam int FLG_HALF   = 1;
   localparam int FLG_NIL    = 2;
   localparam int FLG_RANGE  = 3;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [5:0] REG_INSTR  = 6'h00;
   localparam logic [5:0] REG_STATUS = 6'h04;
   localparam logic [5:0] REG_WORK   = 6'h08;
   localparam logic [5:0] REG_FLAGS  = 6'h0C;
   localparam logic [5:0] REG_TPTR   = 6'h10;
   localparam logic [5:0] REG_THIGH  = 6'h14;
   localparam logic [5:0] REG_PAGE   = 6'h18;
   localparam logic [5:0] REG_PADDR  = 6'h1C;
   localparam logic [5:0] REG_PDATA  = 6'h20;
   localparam logic [5:0] REG_DADDR  = 6'h24;
   localparam logic [5:0] REG_DDATA  = 6'h28;
   localparam logic [5:0] REG_SQCNT  = 6'h2C;

   // instruction register fields
   localparam int INS_OP_LSB  = 0;
   localparam int INS_BIT_LSB = 5;
   localparam int INS_ADR_LSB = 8;
   localparam int INS_IMM_LSB = 16;
   localparam int INS_GO      = 31;

   // status register fields
   localparam int STS_BUSY  = 0;
   localparam int STS_SKIPP = 1;
   localparam int STS_LSKIP = 2;
   localparam int STS_FLAGS = 4;

   // ------------------------------------------------------------
   // reset values and timing
   // ------------------------------------------------------------
   localparam logic [7:0] WORK_RST  = 8'h00;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam int         MC_DIV    = 4;

endpackage : ieu_pkg

// File: ieu_alu.sv
// combinational result and flag logic for one executed instruction
`timescale 1ns/100ps
module ieu_alu
   import ieu_pkg::*;
(
   input  wire ieu_pkg::ieu_op_e op,
   input  wire logic [7:0]       work,
   input  wire logic [7:0]       mem,
   input  wire logic [7:0]       imm,
   input  wire logic [2:0]       bsel,
   input  wire logic [3:0]       flags_in,
   input  wire logic [7:0]       tab_low,
   output logic      [7:0]       result,
   output logic                  wr_mem,
   output logic                  wr_work,
   output logic                  skip,
   output logic      [3:0]       flags_out
);
   import ieu_pkg::*;

   // ------------------------------------------------------------
   // subtraction flags
   // ------------------------------------------------------------
   function automatic logic [3:0] sub_flags(input logic [7:0] a,
                                            input logic [7:0] b);
      logic [8:0] d;
      logic [3:0] f;
      d = {1'b0, a} - {1'b0, b};
      f = '0;
      f[FLG_BORROW] = ~d[8];
      f[FLG_HALF]   = (a[3:0] >= b[3:0]);
      f[FLG_NIL]    = (d[7:0] == 8'h00);
      f[FLG_RANGE]  = (a[7] ^ b[7]) & (a[7] ^ d[7]);
      return f;
   endfunction : sub_flags

   wire logic [7:0] dec_val  = mem - 8'h01;
   wire logic [7:0] inc_val  = mem + 8'h01;
   wire logic [7:0] swp_val  = {mem[3:0], mem[7:4]};
   wire logic [7:0] bit_mask = 8'h01 << bsel;
   wire logic       bit_val  = mem[bsel];
   wire logic [7:0] sub_opnd = (op == OP_SUB_I) ? imm : mem;
   wire logic [7:0] xor_opnd = (op == OP_XOR_I) ? imm : mem;
   wire logic [7:0] xor_val  = work ^ xor_opnd;

   always_comb begin
      result    = mem;
      wr_mem    = 1'b0;
      wr_work   = 1'b0;
      skip      = 1'b0;
      flags_out = flags_in;
      unique case (op)
         OP_DEC_SKIP: begin
            result = dec_val;
            wr_mem = 1'b1;
            skip   = (dec_val == 8'h00);
         end
         OP_DEC_SKIP_W: begin
            result  = dec_val;
            wr_work = 1'b1;
            skip    = (dec_val == 8'h00);
         end
         OP_SET_BYTE: begin
            result = BYTE_ONES;
            wr_mem = 1'b1;
         end
         OP_SET_BIT: begin
            result = mem | bit_mask;
            wr_mem = 1'b1;
         end
         OP_INC_SKIP: begin
            result = inc_val;
            wr_mem = 1'b1;
            skip   = (inc_val == 8'h00);
         end
         OP_INC_SKIP_W: begin
            result  = inc_val;
            wr_work = 1'b1;
            skip    = (inc_val == 8'h00);
         end
         OP_BIT_SKIP_ONE: skip = bit_val;
         OP_SUB_W, OP_SUB_I: begin
            result    = work - sub_opnd;
            wr_work   = 1'b1;
            flags_out = sub_flags(work, sub_opnd);
         end
         OP_SUB_M: begin
            result    = work - mem;
            wr_mem    = 1'b1;
            flags_out = sub_flags(work, mem);
         end
         OP_SWAP_M: begin
            result = swp_val;
            wr_mem = 1'b1;
         end
         OP_SWAP_W: begin
            result  = swp_val;
            wr_work = 1'b1;
         end
         OP_SKIP_NIL: skip = (mem == 8'h00);
         OP_COPY_SKIP_NIL: begin
            result  = mem;
            wr_work = 1'b1;
            skip    = (mem == 8'h00);
         end
         OP_BIT_SKIP_NIL: skip = ~bit_val;
         OP_TAB_CUR, OP_TAB_LAST: begin
            result = tab_low;
            wr_mem = 1'b1;
         end
         OP_XOR_W, OP_XOR_I: begin
            result             = xor_val;
            wr_work            = 1'b1;
            flags_out[FLG_NIL] = (xor_val == 8'h00);
         end
         OP_XOR_M: begin
            result             = xor_val;
            wr_mem             = 1'b1;
            flags_out[FLG_NIL] = (xor_val == 8'h00);
         end
         default: begin
            result = mem;
         end
      endcase
   end

endmodule : ieu_alu

// File: ieu_core.sv
// instruction execution unit with Avalon-MM register access
`timescale 1ns/100ps
module ieu_core #(
   parameter int DMEM_AW   = 5,
   parameter int PROG_AW   = 10,
   parameter int PAGE_BITS = 2,
   parameter int PROG_W    = 14,
   parameter int CYC_PER_MC = ieu_pkg::MC_DIV
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest
);
   import ieu_pkg::*;

   localparam int TP_W = PROG_AW - PAGE_BITS;
   localparam int TH_W = PROG_W - 8;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // lanes that are not enabled keep the current bits
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0]           data_mem [2**DMEM_AW];
   logic [PROG_W-1:0]    prog_mem [2**PROG_AW];

   ieu_state_e           state;
   logic [31:0]          instr;
   logic [7:0]           working_register;
   logic [3:0]           flags;

   logic [TP_W-1:0]      table_pointer;
   logic [TH_W-1:0]      table_high_byte_reg;

   logic [PAGE_BITS-1:0] page;
   logic [PROG_AW-1:0]   paddr;
   logic [DMEM_AW-1:0]   daddr;

   logic                 skip_pending;
   logic                 last_skip;
   logic                 squash;
   logic [7:0]           sq_count;

   logic [7:0]           mc_cnt;
   // rd_done marks the answer cycle of a held read
   logic                 rd_done;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // one word per register, fields low, upper bits zero
   // 00 instr  04 status  08 working  0c flags  10 table ptr
   // 14 table high  18 page  1c prog addr  20 prog word
   // 24 data addr  28 data byte  2c squash count
   // 04, 14, 2c are read only; a prog word write steps prog addr
   // unmapped offsets read zero and drop writes, yet answer

   wire logic busy     = (state != ST_IDLE);

   // every write waits for an idle unit so a register never changes
   // under an instruction that is still in flight
   wire logic wr_ok    = avs_write & ~busy;

   wire logic sel_ins  = (avs_address == REG_INSTR);
   wire logic sel_work = (avs_address == REG_WORK);
   wire logic sel_flg  = (avs_address == REG_FLAGS);
   wire logic sel_tptr = (avs_address == REG_TPTR);
   wire logic sel_page = (avs_address == REG_PAGE);
   wire logic sel_pa   = (avs_address == REG_PADDR);
   wire logic sel_pd   = (avs_address == REG_PDATA);
   wire logic sel_da   = (avs_address == REG_DADDR);
   wire logic sel_dd   = (avs_address == REG_DDATA);

   wire logic [31:0] ins_m  = be_merge(instr, avs_writedata,
                                       avs_byteenable);

   wire logic [31:0] work_m = be_merge({24'h0, working_register},
                                       avs_writedata, avs_byteenable);

   wire logic [31:0] flg_m  = be_merge({28'h0, flags},
                                       avs_writedata, avs_byteenable);

   wire logic [31:0] tp_m   = be_merge(32'(table_pointer),
                                       avs_writedata, avs_byteenable);

   wire logic [31:0] pg_m   = be_merge(32'(page),
                                       avs_writedata, avs_byteenable);

   wire logic [31:0] pa_m   = be_merge(32'(paddr),
                                       avs_writedata, avs_byteenable);

   wire logic [31:0] pd_m   = be_merge(32'(prog_mem[paddr]),
                                       avs_writedata, avs_byteenable);

   wire logic [31:0] da_m   = be_merge(32'(daddr),
                                       avs_writedata, avs_byteenable);

   wire logic [31:0] dd_m   = be_merge({24'h0, data_mem[daddr]},
                                       avs_writedata, avs_byteenable);

   // go needs the top byte lane, so a write without that lane never starts
   wire logic go_wr = wr_ok & sel_ins & avs_byteenable[3]
                      & avs_writedata[INS_GO];

   // reads never wait on busy: status stays readable mid-run
   assign avs_waitrequest = (avs_read & ~rd_done) | (avs_write & busy);

   // ------------------------------------------------------------
   // instruction fields and execution
   // ------------------------------------------------------------
   // opcodes past the last defined one run as no operation
   wire ieu_op_e           op_raw  = ieu_op_e'(instr[INS_OP_LSB +: 5]);
   wire logic [DMEM_AW-1:0] m_addr = instr[INS_ADR_LSB +: DMEM_AW];
   wire logic [7:0]        imm     = instr[INS_IMM_LSB +: 8];
   wire logic [2:0]        bsel    = instr[INS_BIT_LSB +: 3];
   wire logic [7:0]        m_val   = data_mem[m_addr];

   // the last page is all ones, whatever page is selected
   wire logic [PAGE_BITS-1:0] tab_page =
      (op_raw == OP_TAB_LAST) ? {PAGE_BITS{1'b1}} : page;
   wire logic [PROG_W-1:0] tab_word = prog_mem[{tab_page, table_pointer}];
   wire logic tab_op = (op_raw == OP_TAB_CUR) | (op_raw == OP_TAB_LAST);

   wire logic [7:0] alu_res;
   wire logic       alu_wr_mem;
   wire logic       alu_wr_work;
   wire logic       alu_skip;
   wire logic [3:0] alu_flags;

   ieu_alu u_alu (
      .op        (op_raw),
      .work      (working_register),
      .mem       (m_val),
      .imm       (imm),
      .bsel      (bsel),
      .flags_in  (flags),
      .tab_low   (tab_word[7:0]),
      .result    (alu_res),
      .wr_mem    (alu_wr_mem),
      .wr_work   (alu_wr_work),
      .skip      (alu_skip),
      .flags_out (alu_flags)
   );

   // machine cycle tick, counted from the start of each machine cycle
   // a slower machine cycle stretches busy and changes no result
   wire logic mc_tick = (mc_cnt == 8'(CYC_PER_MC - 1));
   wire logic commit  = (state == ST_EXEC) & mc_tick & ~squash;

   wire logic do_mem  = commit & alu_wr_mem;
   wire logic do_work = commit & alu_wr_work;
   wire logic do_skip = commit & alu_skip;

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   // a taken skip adds a dummy machine cycle, the fetch slot of
   // the skipped one; software issues it anyway and it is squashed,
   // so this block needs no program counter
   ieu_state_e next_state;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (go_wr) begin
               next_state = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (mc_tick) begin
               next_state = do_skip ? ST_DUMMY : ST_IDLE;
            end
         end
         ST_DUMMY: begin
            if (mc_tick) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state  <= ST_IDLE;
         mc_cnt <= 8'h00;
      end else begin
         state  <= next_state;
         mc_cnt <= (go_wr | mc_tick | ~busy) ? 8'h00 : mc_cnt + 8'h01;
      end
   end

   // squash captured at issue: the instruction after a taken skip
   // a squashed instruction cannot skip, so skips never chain
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         squash       <= 1'b0;
         skip_pending <= 1'b0;
         last_skip    <= 1'b0;
         sq_count     <= 8'h00;
      end else begin
         if (go_wr) begin
            squash <= skip_pending;
         end
         if (state == ST_EXEC && mc_tick) begin
            last_skip    <= do_skip;
            skip_pending <= do_skip;
            if (squash) begin
               sq_count <= sq_count + 8'h01;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // architectural registers
   // ------------------------------------------------------------
   // commit and bus writes never meet: bus writes wait for idle
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         working_register <= WORK_RST;
         flags            <= FLAGS_RST;
      end else if (commit) begin
         flags <= alu_flags;
         if (do_work) begin
            working_register <= alu_res;
         end
      end else if (wr_ok & sel_work) begin
         working_register <= work_m[7:0];
      end else if (wr_ok & sel_flg) begin
         flags <= flg_m[3:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         instr               <= 32'h0000_0000;
         table_pointer       <= '0;
         table_high_byte_reg <= '0;
         page                <= '0;
         paddr               <= '0;
         daddr               <= '0;
      end else begin
         if (wr_ok & sel_ins) begin
            instr <= ins_m;
         end
         if (wr_ok & sel_tptr) begin
            table_pointer <= tp_m[TP_W-1:0];
         end
         if (commit & tab_op) begin
            table_high_byte_reg <= tab_word[PROG_W-1:8];
         end
         if (wr_ok & sel_page) begin
            page <= pg_m[PAGE_BITS-1:0];
         end
         if (wr_ok & sel_pa) begin
            paddr <= pa_m[PROG_AW-1:0];
         end else if (wr_ok & sel_pd) begin
            paddr <= paddr + PROG_AW'(1);
         end
         if (wr_ok & sel_da) begin
            daddr <= da_m[DMEM_AW-1:0];
         end
      end
   end

   // memories carry no reset; software loads them before use
   always_ff @(posedge sys_clk) begin
      if (do_mem) begin
         data_mem[m_addr] <= alu_res;
      end else if (wr_ok & sel_dd) begin
         data_mem[daddr] <= dd_m[7:0];
      end
      if (wr_ok & sel_pd) begin
         prog_mem[paddr] <= pd_m[PROG_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // read path: one wait cycle, data registered
   // ------------------------------------------------------------
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address)
         REG_INSTR:  rd_mux = instr;
         REG_STATUS: begin
            rd_mux[STS_BUSY]          = busy;
            rd_mux[STS_SKIPP]         = skip_pending;
            rd_mux[STS_LSKIP]         = last_skip;
            rd_mux[STS_FLAGS +: 4]    = flags;
         end
         REG_WORK:   rd_mux[7:0]          = working_register;
         REG_FLAGS:  rd_mux[3:0]          = flags;
         REG_TPTR:   rd_mux[TP_W-1:0]     = table_pointer;
         REG_THIGH:  rd_mux[TH_W-1:0]     = table_high_byte_reg;
         REG_PAGE:   rd_mux[PAGE_BITS-1:0] = page;
         REG_PADDR:  rd_mux[PROG_AW-1:0]  = paddr;
         REG_PDATA:  rd_mux[PROG_W-1:0]   = prog_mem[paddr];
         REG_DADDR:  rd_mux[DMEM_AW-1:0]  = daddr;
         REG_DDATA:  rd_mux[7:0]          = data_mem[daddr];
         REG_SQCNT:  rd_mux[7:0]          = sq_count;
         default:    rd_mux = 32'h0000_0000;
      endcase
   end

   // registering the word keeps memory off the readdata path
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rd_done      <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         rd_done <= avs_read & ~rd_done;
         if (avs_read & ~rd_done) begin
            avs_readdata <= rd_mux;
         end
      end
   end

endmodule : ieu_core

// File: ieu_core_properties.sv
// bus-side properties of the instruction execution unit
`timescale 1ns/100ps
module ieu_core_props #(
   parameter int CYC_PER_MC = 4
) (
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic [5:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest
);
   logic [7:0] stall_cnt;
   wire        rd_ok    = avs_read & ~avs_waitrequest;
   wire        wr_ok    = avs_write & ~avs_waitrequest;
   wire        go_ok    = wr_ok & (avs_address == 6'h00)
                          & avs_writedata[31] & avs_byteenable[3];
   wire        unmapped = (avs_address > 6'h2C) | (avs_address[1:0] != 2'h0);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // a skip doubles the busy span, so a held write may wait twice as long
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         stall_cnt <= 8'h00;
      else if (avs_write & avs_waitrequest)
         stall_cnt <= stall_cnt + 8'h01;
      else
         stall_cnt <= 8'h00;
   end
   property p_rd_first; $rose(avs_read) |-> avs_waitrequest; endproperty
   property p_rd_second;
      avs_read && avs_waitrequest ##1 avs_read |-> !avs_waitrequest;
   endproperty
   property p_go_stall;
      CYC_PER_MC > 1 && go_ok ##2 avs_write |-> avs_waitrequest;
   endproperty
   property p_idle_wr; wr_ok && !go_ok ##2 avs_write |-> !avs_waitrequest;
   endproperty
   property p_stall_max; stall_cnt <= 2 * CYC_PER_MC + 1; endproperty
   property p_rd_hold; !avs_read |=> $stable(avs_readdata); endproperty
   property p_unmap; rd_ok && unmapped |-> avs_readdata == 32'h0000_0000;
   endproperty
   property p_pad;
      rd_ok && (avs_address inside {6'h04, 6'h08, 6'h2C})
         |-> avs_readdata[31:8] == 24'h00_0000;
   endproperty
   property p_thigh;
      rd_ok && avs_address == 6'h14 |-> avs_readdata[31:6] == 26'h000_0000;
   endproperty
   a_rd_first: assert property (p_rd_first) else $error("read acked at once");
   a_rd_second: assert property (p_rd_second) else $error("read ack late");
   a_go_stall: assert property (p_go_stall) else $error("no stall");
   a_idle_wr: assert property (p_idle_wr) else $error("idle stall");
   a_stall_max: assert property (p_stall_max) else $error("long");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_pad: assert property (p_pad) else $error("upper bits not zero");
   a_thigh: assert property (p_thigh) else $error("high byte wide");
   c_go: cover property (go_ok);
   c_skip: cover property (stall_cnt > CYC_PER_MC);
   c_unmap: cover property (rd_ok && unmapped);
endmodule : ieu_core_props

bind ieu_core ieu_core_props #(.CYC_PER_MC(CYC_PER_MC)) u_ieu_core_props (
   .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// File: test_ieu_core.sv
// randomised self-checking bench for the execution unit
`timescale 1ns/100ps
module test_ieu_core;
   logic        sys_clk, rstn, avs_read, avs_write, avs_waitrequest, sk;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rv, r1, r2, r3;
   logic [3:0]  avs_byteenable, f, ef;
   logic [7:0]  w, m, imm, t, r, s, ew, em;
   logic [13:0] pw;
   logic [4:0]  op, a;
   logic [2:0]  b;
   logic [1:0]  pg;
   int          failures, tests_run, seed, i, nw, nsq;

   ieu_core #(.CYC_PER_MC(2)) u_ieu_core (
      .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task end_of_test;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task bus(input logic wr, input logic [5:0] ad, input logic [31:0] d);
      avs_read      <= ~wr;
      avs_write     <= wr;
      avs_address   <= ad;
      avs_writedata <= d;
      @(posedge sys_clk);
      nw = 0;
      while (avs_waitrequest !== 1'b0) begin
         nw++;
         @(posedge sys_clk);
      end
      rv = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask : bus

   task rdc(input logic [5:0] ad, input logic [31:0] exp);
      bus(1'b0, ad, 32'h0000_0000);
      chk(rv, exp);
   endtask : rdc

   // the unmapped write behind the go stalls until the unit is idle again
   task run(input logic [4:0] o, input logic [7:0] x);
      bus(1'b1, 6'h00, {1'b1, 7'h00, x, 3'h0, a, b, o});
      bus(1'b1, 6'h3C, 32'h0000_0000);
   endtask : run

   function automatic logic [7:0] calc(input logic [4:0] o);
      case (o)
         1, 2:    return m - 8'h01;
         5, 6:    return m + 8'h01;
         3:       return 8'hFF;
         4:       return m | (8'h01 << b);
         8, 9:    return w - m;
         10:      return w - imm;
         11, 12:  return {m[3:0], m[7:4]};
         16, 17:  return pw[7:0];
         18, 19:  return w ^ m;
         20:      return w ^ imm;
         default: return m;
      endcase
   endfunction : calc

   initial begin
      seed = 32'h2432;
      failures = 0;
      tests_run = 0;
      nsq = 0;
      rstn = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 6'h00;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      a = 5'h00;
      b = 3'h0;
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      rdc(6'h08, 32'h0000_0000);
      rdc(6'h3C, 32'h0000_0000);
      for (i = 0; i < 300; i++) begin
         r1 = $random(seed);
         r2 = $random(seed);
         r3 = $random(seed);
         op = (i < 128) ? i[4:0] : r3[4:0];
         {w, imm, f, a, b} = r1[27:0];
         {m, t, pw, pg} = r2;
         // boundary bytes: one, all ones, zero
         if (i[6:5] != 2'h0)
            m = (i[6:5] == 2'h1) ? 8'h01 : {8{~i[5]}};
         bus(1'b1, 6'h08, 32'(w));
         bus(1'b1, 6'h0C, 32'(f));
         bus(1'b1, 6'h24, 32'(a));
         bus(1'b1, 6'h28, 32'(m));
         bus(1'b1, 6'h18, 32'(pg));
         bus(1'b1, 6'h10, 32'(t));
         bus(1'b1, 6'h1C, 32'({(op == 5'h11) ? 2'h3 : pg, t}));
         bus(1'b1, 6'h20, 32'(pw));
         r = calc(op);
         s = (op == 5'h0A) ? imm : m;
         ew = w;
         em = m;
         ef = f;
         if (op inside {1, 3, 4, 5, 9, 11, 16, 17, 19})
            em = r;
         if (op inside {2, 6, 8, 10, 12, 14, 18, 20})
            ew = r;
         if (op inside {8, 9, 10})
            ef = {(w[7] != s[7]) && (r[7] != w[7]), r == 8'h00,
                  w[3:0] >= s[3:0], w >= s};
         if (op inside {18, 19, 20})
            ef[2] = (r == 8'h00);
         sk = ((op inside {1, 2, 5, 6, 13, 14}) && r == 8'h00)
              || (op == 5'h07 && m[b]) || (op == 5'h0F && !m[b]);
         run(op, imm);
         chk(32'(nw), sk ? 32'h0000_0003 : 32'h0000_0001);
         rdc(6'h08, 32'(ew));
         rdc(6'h0C, 32'(ef));
         rdc(6'h28, 32'(em));
         rdc(6'h04, {24'h00_0000, ef, 1'b0, sk, sk, 1'b0});
         if (op inside {16, 17})
            rdc(6'h14, 32'(pw[13:8]));
         run(5'h14, 8'h5A);
         rdc(6'h08, 32'(sk ? ew : ew ^ 8'h5A));
         if (sk)
            nsq++;
      end
      rdc(6'h2C, 32'(nsq[7:0]));
      end_of_test;
   end

   initial begin
      repeat (60000) @(posedge sys_clk);
      failures++;
      end_of_test;
   end
endmodule : test_ieu_core
